// *** src/cfd_pkg.sv ***
package cfd_pkg;

    // ------------------------------------------------------------
    // channel settings
    // ------------------------------------------------------------
    localparam logic [1:0] CFD_SET_STANDBY   = 2'h0;
    localparam logic [1:0] CFD_SET_INPUT     = 2'h1;
    localparam logic [1:0] CFD_SET_CONDUCT   = 2'h2;
    localparam logic [1:0] CFD_SET_FORCE_OFF = 2'h3;
    localparam logic [1:0] CFD_SET_RESET     = 2'h3;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CFD_CLK_MHZ            = 100;
    localparam int CFD_OL_DELAY_MIN_US    = 30;
    localparam int CFD_OL_DELAY_MAX_US    = 200;
    localparam int CFD_OVL_DELAY_MIN_US   = 3;
    localparam int CFD_OVL_DELAY_MAX_US   = 50;
    // aim at the lower bound; the counts equal both window minimums, so delays land just inside
    localparam int CFD_OL_DELAY_CYC       = CFD_OL_DELAY_MIN_US * CFD_CLK_MHZ;
    localparam int CFD_OVL_DELAY_CYC      = CFD_OVL_DELAY_MIN_US * CFD_CLK_MHZ;
    localparam int CFD_CNT_W              = 16;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CFD_ADDR_SETTING = 12'h000;
    localparam logic [11:0] CFD_ADDR_FLAGS   = 12'h004;
    localparam logic [11:0] CFD_ADDR_STATUS  = 12'h008;
    localparam logic [11:0] CFD_ADDR_MASK    = 12'h00C;
    localparam logic [11:0] CFD_ADDR_OUTPUT  = 12'h010;
    localparam logic [15:0] CFD_SETTING_RST  = 16'hFFFF;
    localparam logic [15:0] CFD_MASK_RST     = 16'h0000;

endpackage

// *** src/cfd_channel_fault_diagnosis.sv ***
`timescale 1ns/1ps
// Behaviour
// - an over-temperature report forces the channel off and, outside standby, sets its protective fault flag.
// - a channel shut off by a fault stays off until its protective fault flag is cleared.
// - each channel keeps a sticky protective fault flag for over-temperature and over-load.
// - each channel keeps a sticky open-load flag for open load or short to ground.
// - writing the standby setting clears both flags of a channel and nothing else does.
// - while a channel is on, no open-load detection runs and its open-load flag holds.
// - off with diagnosis, the open-load flag sets after the comparator holds for the delay.
// - off-state diagnosis is on when forced off or pin-off in input mode, off in standby.
// - over-load on an active channel switches it off after the shutdown delay and sets fault.
// - setting codes: 00 standby, 01 follow input pin, 10 forced on, 11 forced off.
// - after reset every setting bit is one, so all channels start forced off.
module cfd_channel_fault_diagnosis
    import cfd_pkg::*;
#(
    parameter int NCH           = 8,
    parameter int OL_DELAY_CYC  = CFD_OL_DELAY_CYC,
    parameter int OVL_DELAY_CYC = CFD_OVL_DELAY_CYC
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // channel pins and comparators
    input  wire logic [NCH-1:0]    chan_in_pin,
    input  wire logic [NCH-1:0]    over_temp,
    input  wire logic [NCH-1:0]    over_load,
    input  wire logic [NCH-1:0]    open_load_cmp,
    // channel drive and interrupt
    output logic      [NCH-1:0]    chan_on,
    output logic                   diag_enable_out,
    output logic                   irq
);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire        acc_phase  = psel & penable;
    // only the first access cycle acts; the answer cycle must not write twice
    wire        first_acc  = acc_phase & ~pready;
    wire        wr_acc     = first_acc & pwrite;
    wire        sel_set    = (paddr == CFD_ADDR_SETTING);
    wire        sel_flags  = (paddr == CFD_ADDR_FLAGS);
    wire        sel_stat   = (paddr == CFD_ADDR_STATUS);
    wire        sel_mask   = (paddr == CFD_ADDR_MASK);
    wire        sel_out    = (paddr == CFD_ADDR_OUTPUT);
    wire        addr_ok    = sel_set | sel_flags | sel_stat | sel_mask | sel_out;
    wire        wr_set     = wr_acc & sel_set;
    wire        wr_stat    = wr_acc & sel_stat;
    wire        wr_mask    = wr_acc & sel_mask;

    logic [15:0]      setting_reg;
    logic [15:0]      setting_next;
    logic [NCH-1:0]   fault_reg;
    logic [NCH-1:0]   ol_reg;
    logic [1:0]       irq_stat_reg;
    logic [1:0]       irq_mask_reg;
    logic [NCH-1:0]   on_reg;
    logic [NCH-1:0]   diag_en;
    logic [NCH-1:0]   want_on;
    logic [NCH-1:0]   fault_set;
    logic [NCH-1:0]   ol_set;
    logic [NCH-1:0]   in_s;
    logic [NCH-1:0]   ot_s;
    logic [NCH-1:0]   ov_s;
    logic [NCH-1:0]   olc_s;

    // byte-lane write of the setting word
    assign setting_next = {pstrb[1] ? pwdata[15:8] : setting_reg[15:8],
                           pstrb[0] ? pwdata[7:0]  : setting_reg[7:0]};

    // ------------------------------------------------------------
    // per channel
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            logic [2:0]           in_sy;
            logic [2:0]           ot_sy;
            logic [2:0]           ov_sy;
            logic [2:0]           olc_sy;
            logic [1:0]           code;
            logic [1:0]           new_code;
            logic                 stb_wr;
            logic [CFD_CNT_W-1:0] ovl_cnt;
            logic [CFD_CNT_W-1:0] ol_cnt;
            logic                 ovl_hit;
            logic                 ol_hit;
            logic                 clr;

            // three-stage sync; only stages two and three are looked at
            // pins and comparators come from outside the pclk domain
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    in_sy  <= 3'h0;
                    ot_sy  <= 3'h0;
                    ov_sy  <= 3'h0;
                    olc_sy <= 3'h0;
                end
                else
                begin
                    in_sy  <= {in_sy[1:0], chan_in_pin[g]};
                    ot_sy  <= {ot_sy[1:0], over_temp[g]};
                    ov_sy  <= {ov_sy[1:0], over_load[g]};
                    olc_sy <= {olc_sy[1:0], open_load_cmp[g]};
                end
            end

            // filtered levels: change only once stages two and three agree
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    in_s[g]  <= 1'b0;
                    ot_s[g]  <= 1'b0;
                    ov_s[g]  <= 1'b0;
                    olc_s[g] <= 1'b0;
                end
                else
                begin
                    if (in_sy[1] == in_sy[2])
                        in_s[g]  <= in_sy[2];
                    if (ot_sy[1] == ot_sy[2])
                        ot_s[g]  <= ot_sy[2];
                    if (ov_sy[1] == ov_sy[2])
                        ov_s[g]  <= ov_sy[2];
                    if (olc_sy[1] == olc_sy[2])
                        olc_s[g] <= olc_sy[2];
                end
            end

            assign code     = setting_reg[2*g+1:2*g];
            assign new_code = setting_next[2*g+1:2*g];
            // a standby write clears; a standing standby setting keeps them clear
            assign stb_wr   = wr_set & (new_code == CFD_SET_STANDBY);
            assign clr      = stb_wr | (code == CFD_SET_STANDBY);

            // input mode: diagnosis only while the pin keeps the channel off
            assign diag_en[g] = (code == CFD_SET_FORCE_OFF) |
                                ((code == CFD_SET_INPUT) & ~in_s[g]);
            assign want_on[g] = (code == CFD_SET_CONDUCT) |
                                ((code == CFD_SET_INPUT) & in_s[g]);

            // over-load timer runs only while the channel conducts
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ovl_cnt <= '0;
                else if (!(ov_s[g] & on_reg[g]))
                    ovl_cnt <= '0;
                else if (!ovl_hit)
                    ovl_cnt <= ovl_cnt + 1'b1;
            end
            // held at the limit, so a standing overload never wraps and re-arms
            assign ovl_hit = (ovl_cnt >= CFD_CNT_W'(OVL_DELAY_CYC));

            // open-load timer only while off with diagnosis enabled
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    ol_cnt <= '0;
                else if (!(olc_s[g] & diag_en[g] & ~on_reg[g]))
                    ol_cnt <= '0;
                else if (!ol_hit)
                    ol_cnt <= ol_cnt + 1'b1;
            end
            // held at the limit, like the over-load timer
            assign ol_hit = (ol_cnt >= CFD_CNT_W'(OL_DELAY_CYC));

            assign fault_set[g] = ot_s[g] | ovl_hit;
            assign ol_set[g]    = ol_hit & diag_en[g] & ~on_reg[g];

            // sticky flags; a standby setting wins since it also forces the channel off
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    fault_reg[g] <= 1'b0;
                    ol_reg[g]    <= 1'b0;
                end
                else
                begin
                    fault_reg[g] <= ~clr & (fault_reg[g] | fault_set[g]);
                    ol_reg[g]    <= ~clr & (ol_reg[g] | ol_set[g]);
                end
            end

            // a set fault flag blocks turn-on until cleared
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    on_reg[g] <= 1'b0;
                else
                    on_reg[g] <= want_on[g] & ~fault_reg[g] & ~fault_set[g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    // status bit 0: any fault flag rose, bit 1: any open-load flag rose
    logic [NCH-1:0] fault_d;
    logic [NCH-1:0] ol_d;
    wire  [1:0]     ev        = {|(ol_reg & ~ol_d), |(fault_reg & ~fault_d)};
    wire  [1:0]     stat_clr  = wr_stat ? pwdata[1:0] : 2'h0;
    // set wins: an event in the clearing cycle is not lost
    wire  [1:0]     stat_next = ev | (irq_stat_reg & ~stat_clr);
    wire            mask_wr   = wr_mask & pstrb[0];
    // irq follows a mask write at once, with no stale cycle after it
    wire  [1:0]     mask_next = mask_wr ? pwdata[1:0] : irq_mask_reg;

    // setting word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            setting_reg <= CFD_SETTING_RST;
        else if (wr_set)
            setting_reg <= setting_next;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_reg <= CFD_MASK_RST[1:0];
        else
            irq_mask_reg <= mask_next;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_reg <= 2'h0;
        else
            irq_stat_reg <= stat_next;
    end

    // last flag values, reset to the flags' own reset level so no false edge follows
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_d <= '0;
            ol_d    <= '0;
        end
        else
        begin
            fault_d <= fault_reg;
            ol_d    <= ol_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(stat_next & mask_next);
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // flags word: bit 2n fault, bit 2n+1 open load
    logic [31:0] flags_word;
    always_comb
    begin
        flags_word = 32'h0;
        for (int i = 0; i < NCH; i++)
        begin
            flags_word[2*i]   = fault_reg[i];
            flags_word[2*i+1] = ol_reg[i];
        end
    end

    wire [31:0] rd_mux = sel_set   ? {16'h0, setting_reg} :
                         sel_flags ? flags_word :
                         sel_stat  ? {30'h0, irq_stat_reg} :
                         sel_mask  ? {30'h0, irq_mask_reg} :
                         sel_out   ? {{(32-NCH){1'b0}}, on_reg} : 32'h0;

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= first_acc;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr <= 1'b0;
        else
            pslverr <= first_acc & ~addr_ok;
    end

    // read data is zero outside the answer cycle, so a late sample shows up
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else
            prdata <= (first_acc & ~pwrite) ? rd_mux : 32'h0;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chan_on <= '0;
        else
            chan_on <= on_reg;
    end

    // one summary bit: the diagnosis current source is shared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            diag_enable_out <= 1'b0;
        else
            diag_enable_out <= |diag_en;
    end

endmodule

// *** test/cfd_asserts.sv ***
`timescale 1ns/1ps
module cfd_asserts #(
    parameter int NCH = 8
)(
    // clock and reset
    input wire logic           pclk,
    input wire logic           presetn,
    // apb
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    input wire logic           pslverr,
    input wire logic [31:0]    prdata,
    // channels
    input wire logic [NCH-1:0] over_temp,
    input wire logic [NCH-1:0] over_load,
    input wire logic [NCH-1:0] chan_on,
    input wire logic           diag_enable_out,
    input wire logic           irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_ready_next: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_hot_off: assert property (over_temp[0][*8] ##1 over_temp[0][*5] |-> !chan_on[0])
        else $error("hot channel still on");
    a_load_off: assert property (
        $rose(over_load[0]) && chan_on[0] |-> chan_on[0][*5] ##[1:12] !chan_on[0])
        else $error("overload shutdown timing wrong");
    a_reset_idle: assert property ($rose(presetn) |-> chan_on == '0 && !irq)
        else $error("outputs active after reset");
    a_diag_start: assert property ($rose(presetn) |=> diag_enable_out)
        else $error("diagnosis not enabled after reset");
endmodule

// *** test/cfd_load_model.sv ***
`timescale 1ns/1ps
module cfd_load_model (
    // faults commanded by the bench
    input wire logic [7:0] hot,
    input wire logic [7:0] short_load,
    input wire logic [7:0] open_load,
    input wire logic [7:0] cmp_force,
    // device side
    input wire logic [7:0] chan_on,
    output logic     [7:0] over_temp,
    output logic     [7:0] over_load,
    output logic     [7:0] open_load_cmp
);
    assign over_temp = hot;
    // a short only draws current while conducting
    assign over_load = short_load & chan_on;
    // cmp_force is a deliberately faulty comparator, used to probe the on-state case
    assign open_load_cmp = (open_load & ~chan_on) | cmp_force;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import cfd_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, diag_enable_out, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [3:0]  pstrb;
    logic [7:0]  chan_in_pin, hot, short_load, open_load, cmp_force;
    logic [7:0]  over_temp, over_load, open_load_cmp, chan_on;
    int          errors, checks_done;

    cfd_channel_fault_diagnosis #(.NCH(8), .OL_DELAY_CYC(20), .OVL_DELAY_CYC(5)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .chan_in_pin, .over_temp, .over_load, .open_load_cmp, .chan_on,
        .diag_enable_out, .irq);
    cfd_load_model u_load (.hot, .short_load, .open_load, .cmp_force, .chan_on, .over_temp,
        .over_load, .open_load_cmp);

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // bit 8 is the diagnosis summary, bits 7:0 the channel drive
    function automatic logic [8:0] exp_out(input logic [15:0] s, input logic [7:0] p);
        logic [8:0] r;
        r = 9'h0;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = s[2*i +: 2] == CFD_SET_CONDUCT || (s[2*i +: 2] == CFD_SET_INPUT && p[i]);
            r[8] |= s[2*i +: 2] == CFD_SET_FORCE_OFF || (s[2*i +: 2] == CFD_SET_INPUT && !p[i]);
        end
        return r;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 8);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 8)
        begin
            errors++;
            end_sim();
        end
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        {errors, checks_done, psel, penable, pwrite, paddr, pwdata} = '0;
        {chan_in_pin, hot, short_load, open_load, cmp_force} = '0;
        pstrb = 4'hF;
        seed = 32'h214AC6CD;
        presetn = 1'b0;
        wt(2);
        presetn <= 1'b1;
        // ----------------------------------------
        // reset values, unmapped access
        // ----------------------------------------
        apb(1'b0, CFD_ADDR_SETTING, 32'h0);
        chk(rd, 32'h0000FFFF);
        chk(diag_enable_out, 32'h1);
        apb(1'b0, 12'h0FC, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        // over-temperature on a forced-on channel, then irq mask and clear
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFFE);
        wt(10);
        chk(chan_on, 32'h1);
        hot <= 8'h01;
        wt(16);
        chk(chan_on, 32'h0);
        hot <= 8'h00;
        wt(16);
        chk(chan_on, 32'h0);
        apb(1'b0, CFD_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h1);
        chk(irq, 32'h0);
        apb(1'b1, CFD_ADDR_MASK, 32'h3);
        wt(2);
        chk(irq, 32'h1);
        apb(1'b1, CFD_ADDR_STATUS, 32'h3);
        wt(2);
        chk(irq, 32'h0);
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFFC);
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFFE);
        apb(1'b0, CFD_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        wt(10);
        chk(chan_on, 32'h1);
        // over-load: survives the shutdown delay, then trips
        short_load <= 8'h01;
        wt(6);
        chk(chan_on, 32'h1);
        wt(24);
        chk(chan_on, 32'h0);
        short_load <= 8'h00;
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFFF);
        apb(1'b0, CFD_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h1);
        // open load: ch0 forced off, ch1 standby, ch2 on with a stuck comparator
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFFC);
        apb(1'b1, CFD_ADDR_SETTING, 32'h0000FFE3);
        open_load <= 8'h03;
        cmp_force <= 8'h04;
        wt(8);
        apb(1'b0, CFD_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h0);
        wt(30);
        apb(1'b0, CFD_ADDR_FLAGS, 32'h0);
        chk(rd, 32'h2);
        open_load <= 8'h00;
        cmp_force <= 8'h00;
        apb(1'b1, CFD_ADDR_SETTING, 32'h0);
        // random settings and pins
        repeat (16)
        begin
            seed = lfsr(seed);
            chan_in_pin <= seed[31:24];
            apb(1'b1, CFD_ADDR_SETTING, {16'h0, seed[15:0]});
            wt(12);
            chk({diag_enable_out, chan_on}, exp_out(seed[15:0], seed[31:24]));
            apb(1'b0, CFD_ADDR_SETTING, 32'h0);
            chk(rd, {16'h0, seed[15:0]});
        end
        end_sim();
    end
endmodule

bind cfd_channel_fault_diagnosis cfd_asserts #(.NCH(NCH)) u_chk (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .prdata, .over_temp, .over_load, .chan_on, .diag_enable_out, .irq);
